/* File: core/fbn_link_if.sv */
// Object-write link between the fieldbus master end and the node end
`timescale 1ns/100ps
`default_nettype none
interface fbn_link_if;
   logic       req;    // Master holds a write request
   logic [7:0] cls;    // Object class
   logic [7:0] attr;   // Object attribute
   logic [7:0] data;   // Value written
   logic       ack;    // Node answer pulse
   logic       nak;    // With ack: write refused
   modport node   (input req, cls, attr, data, output ack, nak);
   modport master (output req, cls, attr, data, input ack, nak);
endinterface
`default_nettype wire

/* File: core/fbn_master.sv */
// Master end: AHB-Lite registers that issue object writes to the node
`timescale 1ns/100ps
`default_nettype none
module fbn_master
   import fbn_pkg::*;
(
   input  wire logic        hclk,       // System clock
   input  wire logic        hresetn,    // Async reset, active low
   input  wire logic        hsel,       // Slave select
   input  wire logic [7:0]  haddr,      // Byte address
   input  wire logic [1:0]  htrans,     // Transfer type
   input  wire logic        hwrite,     // Write
   input  wire logic [2:0]  hsize,      // Size, words only
   input  wire logic [31:0] hwdata,     // Write data
   input  wire logic        hready,     // Bus ready
   output logic [31:0]      hrdata,     // Read data
   output logic             hreadyout,  // Always ready
   output logic             hresp,      // Always OKAY
   output logic             irq,        // Level interrupt
   fbn_link_if.master       link        // Object writes to node
);
   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic       wr_pend;   // Data phase of a write
   logic [7:0] wr_addr;   // Its address
   logic       last_nak;  // Last answer was a refusal
   logic [1:0] irq_stat;  // Sticky events
   logic [1:0] irq_mask;  // Enables
   logic [1:0] irq_set;   // Events this cycle
   logic       cmd_wr;    // Command register written

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign cmd_wr    = wr_pend && (wr_addr == REG_CMD) && !link.req;
   assign irq_set   = {link.ack && link.nak, link.ack && !link.nak};
   assign irq       = |(irq_stat & irq_mask);

   // Address phase capture; reads answer in the following cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_addr <= haddr;
         hrdata  <= 32'h0;
         if (hsel && htrans[1] && !hwrite) begin
            case (haddr)
               REG_CMD:      hrdata <= {8'h00, link.data, link.attr, link.cls};
               REG_STAT:     hrdata <= {30'h0, last_nak, link.req};
               REG_IRQ_STAT: hrdata <= {30'h0, irq_stat};
               REG_IRQ_MASK: hrdata <= {30'h0, irq_mask};
               default:      hrdata <= 32'h0;
            endcase
         end
      end
   end

   // Interrupt status: set wins over write-one-to-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end else begin
         if (wr_pend && wr_addr == REG_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~hwdata[1:0]) | irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         if (wr_pend && wr_addr == REG_IRQ_MASK) begin
            irq_mask <= hwdata[1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Link request
   // ------------------------------------------------------------
   // A command written while busy is dropped; software polls busy first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.req  <= 1'b0;
         link.cls  <= 8'h00;
         link.attr <= 8'h00;
         link.data <= 8'h00;
         last_nak  <= 1'b0;
      end else if (cmd_wr) begin
         link.req  <= 1'b1;
         link.cls  <= hwdata[7:0];
         link.attr <= hwdata[15:8];
         link.data <= hwdata[23:16];
      end else if (link.ack) begin
         // save object goes through the same path
         link.req  <= 1'b0;
         last_nak  <= link.nak;
      end
   end
endmodule
`default_nettype wire

/* File: core/fbn_node.sv */
// Node end: station address, bit rate and combined status LED of the fieldbus card
// Functional notes
// - Switches 0..63 give the station address
// - Above 63 use stored, terminal-set address
// - Above 63 accept network address write
// - Network address needs save and restart
// - Rate switch 0,1,2 gives 125,250,500
// - Rate switch above 2 uses stored rate
// - Above 2 accept network rate code
// - Network rate needs save and restart
// - LED off while not online; a fault shown in red takes priority
// - Steady green when fully operational
// - Blinking green when online, not connected
// - Blinking red on recoverable fault or wait
// - Steady red on fatal or bus-off fault
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module fbn_node
   import fbn_pkg::*;
#(
   parameter int BLINK_CYC = BLINK_HALF_CYC       // Cycles per blink half period
) (
   input  wire logic       hclk,                  // System clock
   input  wire logic       hresetn,               // Async reset, active low
   fbn_link_if.node        link,                  // Network object writes
   input  wire logic [3:0] sw_addr_msd,           // Address switch, tens digit (pin)
   input  wire logic [3:0] sw_addr_lsd,           // Address switch, units digit (pin)
   input  wire logic [3:0] sw_rate,               // Bit-rate switch (pin)
   input  wire logic       node_address_set_command, // Terminal: set stored address
   input  wire logic [6:0] node_address_value,    // Argument of the above
   input  wire logic       bit_rate_set_command,  // Terminal: set stored rate
   input  wire logic [8:0] bit_rate_kbps,         // Argument in kbit/s
   input  wire logic       save_command,          // Terminal: save to nonvolatile
   input  wire logic       cold_restart_command,  // Restart pulse
   input  wire logic       online,                // Node is online
   input  wire logic       dup_check_done,        // Duplicate-ID check passed
   input  wire logic       conn_established,      // Connections established
   input  wire logic       master_allocated,      // Allocated to a master
   input  wire logic       config_ok,             // Configuration complete and valid
   input  wire logic       fault_recoverable,     // Recoverable fault present
   input  wire logic       io_conn_waiting,       // An I/O connection waits
   input  wire logic       fault_fatal,           // Unrecoverable fault
   input  wire logic       dup_id_detected,       // Duplicate station address seen
   input  wire logic       bus_off,               // Controller is bus-off
   output logic [6:0]      station_address,       // Active station address
   output logic [1:0]      bit_rate_code,         // Active bit-rate code
   output logic            config_valid,          // Active settings latched
   output logic            terminal_refused,      // Pulse: terminal command refused
   output logic            led_green,             // Status LED green
   output logic            led_red                // Status LED red
);
   // ------------------------------------------------------------
   // Switch synchronisers
   // ------------------------------------------------------------
   logic [11:0] sw_meta;      // First stage, read only by second stage
   logic [11:0] sw_sync;      // Second stage
   logic [6:0]  sw_addr;      // Decimal switch value
   logic        addr_use_nv;  // Address switches above limit
   logic        rate_use_nv;  // Rate switch above limit
   // Rotary switches are asynchronous pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_meta <= 12'h000;
         sw_sync <= 12'h000;
      end else begin
         sw_meta <= {sw_addr_msd, sw_addr_lsd, sw_rate};
         sw_sync <= sw_meta;
      end
   end

   // Tens times ten plus units in 7 bits; a tens digit above 9 is flagged below, a units digit above 9 is not
   assign sw_addr     = 7'(sw_sync[11:8]) * 7'h0A + 7'(sw_sync[7:4]);
   assign addr_use_nv = (sw_sync[11:8] > 4'h9) || (sw_addr > ADDR_MAX);
   assign rate_use_nv = (sw_sync[3:0] > 4'(RATE_MAX));

   // ------------------------------------------------------------
   // Start-up sampling
   // ------------------------------------------------------------
   logic [1:0] settle_cnt;   // Cycles until switches are stable
   logic       sampling;     // Waiting to latch active settings
   logic       take;         // Latch strobe
   logic       addr_nv_mode; // Latched: address comes from store
   logic       rate_nv_mode; // Latched: rate comes from store
   logic [6:0] nv_addr;      // Stored address
   logic [1:0] nv_rate;      // Stored rate
   logic [6:0] pend_addr;    // Address awaiting save
   logic [1:0] pend_rate;    // Rate awaiting save
   assign take = sampling && (settle_cnt == SETTLE_CYC);
   // Restart re-arms sampling; running switch moves are ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sampling   <= 1'b1;
         settle_cnt <= 2'h0;
      end else if (cold_restart_command) begin
         sampling   <= 1'b1;
         settle_cnt <= 2'h0;
      end else if (take) begin
         sampling   <= 1'b0;
      end else if (sampling) begin
         settle_cnt <= settle_cnt + 2'h1;
      end
   end

   // Active settings and source flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         station_address <= 7'h00;
         bit_rate_code   <= RATE_125;
         addr_nv_mode    <= 1'b0;
         rate_nv_mode    <= 1'b0;
         config_valid    <= 1'b0;
      end else if (cold_restart_command) begin
         config_valid    <= 1'b0;
      end else if (take) begin
         config_valid    <= 1'b1;
         addr_nv_mode    <= addr_use_nv;
         rate_nv_mode    <= rate_use_nv;
         station_address <= addr_use_nv ? nv_addr : sw_addr;
         bit_rate_code   <= rate_use_nv ? nv_rate : sw_sync[1:0];
      end
   end

   // ------------------------------------------------------------
   // Network object writes
   // ------------------------------------------------------------
   logic net_addr_ok;  // Address write acceptable
   logic net_rate_ok;  // Rate write acceptable
   logic net_save;     // Save object written
   logic net_take;     // New request this cycle
   assign net_take    = link.req && !link.ack;
   assign net_addr_ok = (link.cls == CLS_LINK) && (link.attr == ATT_ADDR)
                        && addr_nv_mode && (link.data <= 8'(ADDR_MAX));
   // rate code 0..2 in store mode
   assign net_rate_ok = (link.cls == CLS_LINK) && (link.attr == ATT_RATE)
                        && rate_nv_mode && (link.data <= 8'(RATE_MAX));
   assign net_save    = (link.cls == CLS_STORE) && (link.attr == ATT_SAVE);

   // One answer per request; the master drops req on ack
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link.ack <= 1'b0;
         link.nak <= 1'b0;
      end else begin
         link.ack <= net_take;
         link.nak <= net_take && !(net_addr_ok || net_rate_ok || net_save);
      end
   end

   // ------------------------------------------------------------
   // Terminal commands and stored values
   // ------------------------------------------------------------
   logic       term_rate_ok; // Argument is a known rate
   logic [1:0] term_rate;    // Code for the argument
   // Map kbit/s argument to rate code
   always_comb begin
      term_rate_ok = 1'b1;
      term_rate    = RATE_125;
      case (bit_rate_kbps)
         KBPS_125: term_rate = RATE_125;
         KBPS_250: term_rate = RATE_250;
         KBPS_500: term_rate = RATE_500;
         default:  term_rate_ok = 1'b0;
      endcase
   end

   // Pending values; a terminal command wins over a same-cycle network write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_addr <= NV_ADDR_RST;
         pend_rate <= NV_RATE_RST;
      end else begin
         if (node_address_set_command && addr_nv_mode && node_address_value <= ADDR_MAX) begin
            pend_addr <= node_address_value;
         end else if (net_take && net_addr_ok) begin
            pend_addr <= link.data[6:0];
         end
         if (bit_rate_set_command && rate_nv_mode && term_rate_ok) begin
            pend_rate <= term_rate;
         end else if (net_take && net_rate_ok) begin
            pend_rate <= link.data[1:0];
         end
      end
   end

   // Save copies pending into store; the active value waits for restart
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nv_addr <= NV_ADDR_RST;
         nv_rate <= NV_RATE_RST;
      end else if (save_command || (net_take && net_save)) begin
         nv_addr <= pend_addr;
         nv_rate <= pend_rate;
      end
   end

   // Terminal commands refused outside store mode or with bad argument
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         terminal_refused <= 1'b0;
      end else begin
         terminal_refused <= (node_address_set_command
                              && (!addr_nv_mode || node_address_value > ADDR_MAX))
                          || (bit_rate_set_command && (!rate_nv_mode || !term_rate_ok));
      end
   end

   // ------------------------------------------------------------
   // Combined status LED
   // ------------------------------------------------------------
   logic [31:0] blink_cnt;  // Blink divider
   logic        blink_on;   // Blink phase
   fbn_led_e    led_mode;   // Selected display
   // Half-period enable toggles the blink phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blink_cnt <= 32'h0;
         blink_on  <= 1'b0;
      end else if (blink_cnt == 32'(BLINK_CYC - 1)) begin
         blink_cnt <= 32'h0;
         blink_on  <= !blink_on;
      end else begin
         blink_cnt <= blink_cnt + 32'h1;
      end
   end

   // Faults outrank network state
   always_comb begin
      if (fault_fatal || dup_id_detected || bus_off) begin
         led_mode = LED_RED;
      end else if (fault_recoverable || io_conn_waiting) begin
         led_mode = LED_BLINK_RED;
      end else if (!online || !dup_check_done) begin
         led_mode = LED_OFF;
      end else if (conn_established && master_allocated && config_ok) begin
         led_mode = LED_GREEN;
      end else begin
         led_mode = LED_BLINK_GREEN;
      end
   end

   // Registered LED drive
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         led_green <= 1'b0;
         led_red   <= 1'b0;
      end else begin
         case (led_mode)
            LED_GREEN:       {led_green, led_red} <= 2'h2;
            LED_BLINK_GREEN: {led_green, led_red} <= {blink_on, 1'b0};
            LED_BLINK_RED:   {led_green, led_red} <= {1'b0, blink_on};
            LED_RED:         {led_green, led_red} <= 2'h1;
            default:         {led_green, led_red} <= 2'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: core/fbn_pkg.sv */
// Shared constants and types for the fieldbus node configuration and status ends
package fbn_pkg;
   // ------------------------------------------------------------
   // Address and bit-rate selection
   // ------------------------------------------------------------
   localparam logic [6:0] ADDR_MAX      = 7'h3F;  // Highest switch address used directly
   localparam logic [1:0] RATE_MAX      = 2'h2;   // Highest switch bit-rate code used directly
   localparam logic [1:0] RATE_125      = 2'h0;   // 125 kbit/s code
   localparam logic [1:0] RATE_250      = 2'h1;   // 250 kbit/s code
   localparam logic [1:0] RATE_500      = 2'h2;   // 500 kbit/s code
   localparam logic [8:0] KBPS_125      = 9'h07D; // Terminal argument 125
   localparam logic [8:0] KBPS_250      = 9'h0FA; // Terminal argument 250
   localparam logic [8:0] KBPS_500      = 9'h1F4; // Terminal argument 500
   localparam logic [6:0] NV_ADDR_RST   = 7'h3F;  // Stored address before any save
   localparam logic [1:0] NV_RATE_RST   = 2'h0;   // Stored bit rate before any save
   // ------------------------------------------------------------
   // Network objects
   // ------------------------------------------------------------
   localparam logic [7:0] CLS_LINK      = 8'h03;  // Link object class
   localparam logic [7:0] ATT_ADDR      = 8'h01;  // Station address attribute
   localparam logic [7:0] ATT_RATE      = 8'h02;  // Bit-rate attribute
   localparam logic [7:0] CLS_STORE     = 8'h25;  // Parameter storage class
   localparam logic [7:0] ATT_SAVE      = 8'h65;  // Save-to-nonvolatile attribute
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int         CLK_PERIOD_NS = 10;          // 100 MHz system clock
   localparam int         BLINK_HALF_NS = 500_000_000; // Half period of a blinking LED
   localparam int         BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
   localparam logic [1:0] SETTLE_CYC    = 2'h3;   // Wait for switch synchronisers
   // ------------------------------------------------------------
   // Controller registers (AHB-Lite byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CMD       = 8'h00;  // Object write: class, attribute, data
   localparam logic [7:0] REG_STAT      = 8'h04;  // Busy and last answer
   localparam logic [7:0] REG_IRQ_STAT  = 8'h08;  // Sticky events, write one to clear
   localparam logic [7:0] REG_IRQ_MASK  = 8'h0C;  // Interrupt enables
   localparam int         IRQ_DONE      = 0;      // Accepted write finished
   localparam int         IRQ_REFUSED   = 1;      // Write refused by node
   // LED display modes
   typedef enum logic [2:0] {LED_OFF, LED_GREEN, LED_BLINK_GREEN, LED_BLINK_RED, LED_RED} fbn_led_e;
endpackage

/* File: verif/fbn_link_assertions.sv */
// Protocol checker for the object-write link between master and node
`timescale 1ns/100ps
`default_nettype none
module fbn_link_assertions
   import fbn_pkg::*;
(
   input wire logic       hclk,    // System clock
   input wire logic       hresetn, // Async reset, active low
   input wire logic       req,     // Master request
   input wire logic [7:0] cls,     // Object class
   input wire logic [7:0] attr,    // Object attribute
   input wire logic [7:0] data,    // Value written
   input wire logic       ack,     // Node answer pulse
   input wire logic       nak      // Refusal flag
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ------------------------------------------------------------
   // Object decode and transfer steps
   // ------------------------------------------------------------
   wire logic is_addr = (cls == CLS_LINK) && (attr == ATT_ADDR);  // Address write
   wire logic is_rate = (cls == CLS_LINK) && (attr == ATT_RATE);  // Rate write
   wire logic is_save = (cls == CLS_STORE) && (attr == ATT_SAVE); // Save request
   sequence taken_s; req && !ack; endsequence                  // Node takes request
   sequence answer_s; ack ##1 (!ack && !req); endsequence     // One pulse, then release
   // ------------------------------------------------------------
   // Link assertions
   // ------------------------------------------------------------
   chk_answer_once: assert property (taken_s |=> answer_s)
      else $error("link answer missing or too long");
   chk_ack_with_req: assert property (ack |-> req)
      else $error("answer without request");
   chk_nak_with_ack: assert property (nak |-> ack)
      else $error("refusal outside answer");
   chk_request_held: assert property (taken_s |=> req && $stable({cls, attr, data}))
      else $error("request dropped or changed");
   chk_addr_range: assert property (ack && is_addr && data > {1'b0, ADDR_MAX} |-> nak)
      else $error("address above range accepted");
   chk_rate_range: assert property (ack && is_rate && data > {6'h00, RATE_MAX} |-> nak)
      else $error("rate code above range accepted");
   chk_save_taken: assert property (ack && is_save |-> !nak)
      else $error("save request refused");
   chk_other_object: assert property (ack && !is_addr && !is_rate && !is_save |-> nak)
      else $error("unknown object accepted");
endmodule
`default_nettype wire

/* File: verif/fieldbus_node_config_status_test.sv */
// Self-checking bench joining the fieldbus master end and node end
`timescale 1ns/100ps
`default_nettype none
module fieldbus_node_config_status_test import fbn_pkg::*;;
   logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq; // Bus control
   logic [7:0]  haddr;                                           // Bus address
   logic [1:0]  htrans;                                          // Transfer type
   logic [2:0]  hsize;                                           // Transfer size
   logic [31:0] hwdata, hrdata, r;                               // Bus data
   logic [3:0]  sw_msd, sw_lsd, sw_rt;                           // Rotary switches
   logic        na_cmd, br_cmd, sv_cmd, rs_cmd;                  // Terminal pulses
   logic [6:0]  na_val, sa;                                      // Address in, active address
   logic [8:0]  br_kbps;                                         // Rate argument
   logic [9:0]  st;                                              // Status inputs
   logic [1:0]  brc;                                             // Active rate code
   logic        cv, tref, lg, lr;                                // Node flags, LEDs
   int          failures, total_checks, n, i, k, ng, nr;         // Counters
   // LED rows: status inputs, green class, red class (0 off, 1 steady, 2 blink)
   logic [13:0] led_rows [10] = '{14'h0000, 14'h2000, 14'h3E04, 14'h3C08, 14'h3608,
                                  14'h3F02, 14'h3E82, 14'h3E41, 14'h0021, 14'h2011};
   // Switch rows: msd, lsd, rate switch, expected address byte, expected code
   logic [23:0] cfg_rows [3] = '{24'h1010A1, 24'h6303F0, 24'h002002};
   fbn_link_if fbn_link_if_i ();
   fbn_master fbn_master_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .irq(irq), .link(fbn_link_if_i));
   // Short blink keeps LED sampling windows small
   fbn_node #(.BLINK_CYC(4)) fbn_node_i (.hclk(hclk), .hresetn(hresetn), .link(fbn_link_if_i),
      .sw_addr_msd(sw_msd), .sw_addr_lsd(sw_lsd), .sw_rate(sw_rt), .node_address_set_command(na_cmd),
      .node_address_value(na_val), .bit_rate_set_command(br_cmd), .bit_rate_kbps(br_kbps),
      .save_command(sv_cmd), .cold_restart_command(rs_cmd), .online(st[9]), .dup_check_done(st[8]),
      .conn_established(st[7]), .master_allocated(st[6]), .config_ok(st[5]), .fault_recoverable(st[4]),
      .io_conn_waiting(st[3]), .fault_fatal(st[2]), .dup_id_detected(st[1]), .bus_off(st[0]),
      .station_address(sa), .bit_rate_code(brc), .config_valid(cv), .terminal_refused(tref),
      .led_green(lg), .led_red(lr));
   fbn_link_assertions fbn_link_assertions_i (.hclk(hclk), .hresetn(hresetn), .req(fbn_link_if_i.req),
      .cls(fbn_link_if_i.cls), .attr(fbn_link_if_i.attr), .data(fbn_link_if_i.data),
      .ack(fbn_link_if_i.ack), .nak(fbn_link_if_i.nak));
   // ------------------------------------------------------------
   // Helper tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One AHB-Lite single word transfer; entered just after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   // Object write, wait for the link to go idle, check and clear the event bits
   task automatic obj(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d, input logic bad);
      ahb(1'b1, REG_CMD, {8'h00, d, a, c});
      n = 0;
      do begin ahb(1'b0, REG_STAT, 32'h0); n++; end while (r[0] !== 1'b0 && n < 20);
      check(r[0], 1'b0);
      ahb(1'b0, REG_IRQ_STAT, 32'h0);
      check(r, bad ? 32'h2 : 32'h1);
      ahb(1'b1, REG_IRQ_STAT, 32'h3);
   endtask
   // Bounded wait: switch synchronisers plus settle count
   task automatic wait_valid;
      k = 0;
      while (cv !== 1'b1 && k < 20) begin @(posedge hclk); k++; end
      check(cv, 1'b1);
   endtask
   // Restart pulse, then compare the newly latched settings
   task automatic restart(input logic [6:0] ea, input logic [1:0] er);
      repeat (3) @(posedge hclk);
      rs_cmd <= 1'b1;
      @(posedge hclk) rs_cmd <= 1'b0;
      repeat (2) @(posedge hclk);
      wait_valid();
      check(sa, ea);
      check(brc, er);
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge hclk);
      failures++;
      tally_and_finish();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      failures = 0; total_checks = 0; hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; sw_msd = 4'h1; sw_lsd = 4'h0; sw_rt = 4'h1;
      na_cmd = 1'b0; br_cmd = 1'b0; sv_cmd = 1'b0; rs_cmd = 1'b0; na_val = 7'h00; br_kbps = 9'h000;
      st = 10'h000;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      wait_valid();
      check({sa, brc}, {7'h0A, 2'h1});
      ahb(1'b0, REG_IRQ_MASK, 32'h0);
      check(r, 32'h0);
      check({hresp, irq}, 32'h0);
      for (i = 0; i < 10; i++) begin
         st <= led_rows[i][13:4];
         repeat (3) @(posedge hclk);
         ng = 0; nr = 0;
         repeat (8) begin @(posedge hclk); ng += lg; nr += lr; end
         check({ng == 0 ? 2'h0 : ng == 8 ? 2'h1 : 2'h2, nr == 0 ? 2'h0 : nr == 8 ? 2'h1 : 2'h2},
               led_rows[i][3:0]);
      end
      for (i = 0; i < 3; i++) begin
         {sw_msd, sw_lsd, sw_rt} <= cfg_rows[i][23:12];
         restart(cfg_rows[i][10:4], cfg_rows[i][1:0]);
      end
      // Switch moves without restart leave the active settings alone
      {sw_msd, sw_lsd, sw_rt} <= 12'h220;
      repeat (10) @(posedge hclk);
      check({sa, brc}, {7'h00, 2'h2});
      obj(8'h03, 8'h01, 8'h05, 1'b1);
      obj(8'h03, 8'h02, 8'h01, 1'b1);
      {sw_msd, sw_lsd, sw_rt} <= 12'h643;
      restart(NV_ADDR_RST, NV_RATE_RST);
      obj(8'h03, 8'h01, 8'h05, 1'b0);
      restart(NV_ADDR_RST, NV_RATE_RST);
      obj(8'h03, 8'h02, 8'h02, 1'b0);
      obj(8'h25, 8'h65, 8'h00, 1'b0);
      restart(7'h05, 2'h2);
      obj(8'h03, 8'h01, 8'h40, 1'b1);
      obj(8'h03, 8'h02, 8'h03, 1'b1);
      obj(8'h09, 8'h09, 8'h00, 1'b1);
      na_cmd <= 1'b1; na_val <= 7'h07; br_cmd <= 1'b1; br_kbps <= KBPS_250;
      @(posedge hclk) na_cmd <= 1'b0;
      br_cmd <= 1'b0;
      sv_cmd <= 1'b1;
      @(posedge hclk) sv_cmd <= 1'b0;
      restart(7'h07, 2'h1);
      br_cmd <= 1'b1; br_kbps <= 9'h12C;
      @(posedge hclk) br_cmd <= 1'b0;
      n = 0;
      repeat (4) begin @(posedge hclk); n += tref; end
      check(n, 32'h1);
      // Masked event keeps the line low; unmasking raises it; clearing drops it
      ahb(1'b1, REG_CMD, 32'h00000909);
      repeat (3) ahb(1'b0, REG_STAT, 32'h0);
      check(irq, 1'b0);
      ahb(1'b1, REG_IRQ_MASK, 32'h2);
      @(posedge hclk);
      check(irq, 1'b1);
      ahb(1'b1, REG_IRQ_STAT, 32'h2);
      @(posedge hclk);
      check(irq, 1'b0);
      ahb(1'b0, 8'h10, 32'h0);
      check(r, 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
